// ===== bench/mlt_mac_model.sv
// MAC side of the MII transmit path: a transmit clock and an enable.
// Assumes the bench raises txReq for as long as a frame should last.
`timescale 1ns/1ns
module mlt_mac_model
(
   output logic miiTxClk,
   output logic miiTxEn,
   input wire logic txReq
);
   // Free running and not phase locked to sys_clk, so the sync path is exercised
   initial
   begin
      miiTxClk = 1'b0;
      #3;
      forever
      begin
         #62 miiTxClk = 1'b1;
         #63 miiTxClk = 1'b0;
      end
   end

   // Enable launched just after the rise, so with equal sync depth it is sampled on that same rise
   initial miiTxEn = 1'b0;
   always @(posedge miiTxClk) miiTxEn <= txReq;
endmodule

// ===== bench/mlt_mii_latency_asserts.sv
// Checker for the MII latency shaper: latency windows as cycle bounds.
// Assumes 8 ns sys_clk; upper bounds carry a few cycles of sync slack.
`timescale 1ns/1ns
module mlt_mii_latency_asserts
   import mlt_pkg::*;
#(
   parameter int RX_PIPE = 128
)
(
   input wire logic sys_clk,
   input wire logic arst_n,
   input wire mlt_mode_t mode,
   input wire logic halfDuplex,
   input wire mlt_line_rx_t lineRx,
   input wire logic miiTxClk,
   input wire logic miiTxEn,
   input wire mlt_mii_rx_t miiRx,
   input wire logic miiCrs,
   input wire logic miiCol,
   input wire logic lineTxActive
);
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!arst_n);
   wire isFast = (mode != MLT_MODE_10T);
   wire isTx = (mode == MLT_MODE_100TX);
   wire isFx = (mode == MLT_MODE_100FX);

   property p_crs_on;
      lineRx.start && !miiCrs && isFast |=> !miiCrs [*8] ##[1:16] miiCrs;
   endproperty
   a_crs_on: assert property (p_crs_on) else $error("crs rise off window");
   property p_dv_crs;
      $rose(miiRx.dv) && isFast |-> $past(miiCrs, 3);
   endproperty
   a_dv_crs: assert property (p_dv_crs) else $error("dv too soon after crs");
   property p_crs_off_tx;
      lineRx.stop && miiCrs && !lineTxActive && isTx |=> miiCrs [*8] ##[1:18] !miiCrs;
   endproperty
   a_crs_off_tx: assert property (p_crs_off_tx) else $error("crs fall off window");
   property p_crs_off_fx;
      lineRx.stop && miiCrs && !lineTxActive && isFx |=> miiCrs [*8] ##[8:24] !miiCrs;
   endproperty
   a_crs_off_fx: assert property (p_crs_off_fx) else $error("crs fall off window");
   property p_tx_crs;
      $rose(miiTxEn) && isFast && !miiCrs |=> ##[8:56] miiCrs;
   endproperty
   a_tx_crs: assert property (p_tx_crs) else $error("tx crs missing");
   property p_line_on;
      $rose(miiTxEn) && isFast |=> !lineTxActive [*3] ##[1:30] lineTxActive;
   endproperty
   a_line_on: assert property (p_line_on) else $error("line output off window");
   property p_col_tx;
      lineRx.start && lineTxActive && halfDuplex && isTx |=> !miiCol [*8] ##[8:24] miiCol;
   endproperty
   a_col_tx: assert property (p_col_tx) else $error("col rise off window");
   property p_col_fx;
      lineRx.start && lineTxActive && halfDuplex && isFx |=> !miiCol [*6] ##[1:20] miiCol;
   endproperty
   a_col_fx: assert property (p_col_fx) else $error("col rise off window");
   property p_crs_10;
      lineRx.start && !miiCrs && !isFast |=> ##[1:360] miiCrs;
   endproperty
   a_crs_10: assert property (p_crs_10) else $error("10 crs rise missing");
   property p_dv_off_10;
      $fell(miiRx.dv) && !isFast |-> ##[0:8] !miiCrs;
   endproperty
   a_dv_off_10: assert property (p_dv_off_10) else $error("10 crs late after dv");

   c_rx_10: cover property (lineRx.start && !isFast);
   c_col: cover property ($rose(miiCol));
   c_line: cover property ($rose(lineTxActive));
endmodule

bind mlt_mii_latency mlt_mii_latency_asserts #(.RX_PIPE(RX_PIPE)) mlt_mii_latency_asserts_inst (
   .sys_clk(sys_clk), .arst_n(arst_n), .mode(mode), .halfDuplex(halfDuplex),
   .lineRx(lineRx), .miiTxClk(miiTxClk), .miiTxEn(miiTxEn), .miiRx(miiRx),
   .miiCrs(miiCrs), .miiCol(miiCol), .lineTxActive(lineTxActive));

// ===== bench/mlt_mii_latency_tb.sv
// Self-checking bench for the MII latency shaper with a MAC model.
// Assumes 125 MHz sys_clk and a 125 ns MII transmit clock.
`timescale 1ns/1ns
module mlt_mii_latency_tb import mlt_pkg::*;;
   logic sys_clk, arst_n, halfDuplex, miiTxClk, miiTxEn, txReq, miiCrs, miiCol, lineTxActive;
   mlt_mode_t mode;
   mlt_line_rx_t lineRx;
   mlt_mii_rx_t miiRx;
   int errors, checks, n;

   mlt_mii_latency mlt_mii_latency_inst (.sys_clk(sys_clk), .arst_n(arst_n), .mode(mode),
      .halfDuplex(halfDuplex), .lineRx(lineRx), .miiTxClk(miiTxClk), .miiTxEn(miiTxEn),
      .miiRx(miiRx), .miiCrs(miiCrs), .miiCol(miiCol), .lineTxActive(lineTxActive));
   mlt_mac_model mlt_mac_model_inst (.miiTxClk(miiTxClk), .miiTxEn(miiTxEn), .txReq(txReq));

   initial
   begin
      sys_clk = 1'b0;
      forever #4 sys_clk = ~sys_clk;
   end

   function automatic logic sig(int s);
      case (s)
         0: sig = miiCrs;
         1: sig = miiCol;
         2: sig = miiRx.dv;
         3: sig = lineTxActive;
         default: sig = miiTxEn;
      endcase
   endfunction

   // Tenths of a bit time to whole 8 ns cycles, plus slack for sync stages
   function automatic int lim(int t, int bps, int add);
      lim = t * bps / 80000 + add;
   endfunction

   task automatic complete_run;
      $display("errors %0d checks %0d", errors, checks);
      if (errors == 0 && checks > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask

   task automatic chk_range(string nm, int lo, int hi, int seen);
      checks++;
      if (seen < lo || seen > hi)
      begin
         errors++;
         $display("mismatch %s expected %0d..%0d seen %0d", nm, lo, hi, seen);
      end
   endtask

   task automatic chk_nib(string nm, logic [3:0] exp, logic [3:0] seen);
      checks++;
      if (seen !== exp)
      begin
         errors++;
         $display("mismatch %s expected %h seen %h", nm, exp, seen);
      end
   endtask

   // Counts cycles on from n until signal s shows v
   task automatic meas(int s, logic v, int lo, int hi, string nm);
      while (sig(s) !== v && n <= hi)
      begin
         @(posedge sys_clk);
         #1;
         n++;
      end
      if (sig(s) !== v)
      begin
         errors++;
         $display("mismatch %s expected %b seen timeout", nm, v);
         complete_run();
      end
      else
         chk_range(nm, lo, hi, n);
   endtask

   task automatic pulse(logic isStart);
      lineRx.start = isStart;
      lineRx.stop = !isStart;
      lineRx.valid = isStart;
      @(posedge sys_clk);
      #1;
      lineRx.start = 1'b0;
      lineRx.stop = 1'b0;
      n = 1;
   endtask

   task automatic idle(int c);
      repeat (c) @(posedge sys_clk);
      #1;
   endtask

   task automatic rx_frame(mlt_mode_t m, int bps, int a, int b, int c, int d, int e, int f);
      mode = m;
      halfDuplex = 1'b0;
      pulse(1'b1);
      meas(0, 1'b1, lim(a, bps, -1), lim(b, bps, 6), "crs on");
      n = 0;
      meas(2, 1'b1, lim(c, bps, -1), lim(d, bps, 6), "dv on");
      chk_nib("rx data", 4'h5, miiRx.data);
      idle(40);
      pulse(1'b0);
      meas(0, 1'b0, lim(e, bps, -1), lim(f, bps, 6), "crs off");
      if (m == MLT_MODE_10T)
         chk_nib("dv at crs off", 4'h0, {3'h0, miiRx.dv});
   endtask

   task automatic tx_frame(mlt_mode_t m, int a, int b, int c, int d, int e, int f);
      mode = m;
      txReq = 1'b1;
      n = 0;
      meas(4, 1'b1, 0, 40, "tx enable");
      n = 0;
      meas(3, 1'b1, lim(e, BIT_TIME_100_PS, -1), lim(f, BIT_TIME_100_PS, 22), "line on");
      meas(0, 1'b1, lim(a, BIT_TIME_100_PS, -1), lim(b, BIT_TIME_100_PS, 22), "tx crs on");
      idle(40);
      txReq = 1'b0;
      n = 0;
      meas(4, 1'b0, 0, 40, "tx enable");
      n = 0;
      meas(0, 1'b0, lim(c, BIT_TIME_100_PS, -1), lim(d, BIT_TIME_100_PS, 22), "tx crs off");
   endtask

   task automatic col_frame(mlt_mode_t m, int bps, int a, int b, int c, int d);
      mode = m;
      halfDuplex = 1'b1;
      txReq = 1'b1;
      n = 0;
      meas(4, 1'b1, 0, 40, "tx enable");
      // Let the sampled enable cross into sys_clk before the line starts
      idle(40);
      pulse(1'b1);
      meas(1, 1'b1, lim(a, bps, -1), lim(b, bps, 6), "col on");
      idle(20);
      pulse(1'b0);
      meas(1, 1'b0, lim(c, bps, -1), lim(d, bps, 6), "col off");
      txReq = 1'b0;
      n = 0;
      meas(0, 1'b0, 0, 700, "crs idle");
      halfDuplex = 1'b0;
   endtask

   initial
   begin
      errors = 0;
      checks = 0;
      n = 0;
      mode = MLT_MODE_100TX;
      halfDuplex = 1'b0;
      lineRx = '0;
      lineRx.data = 4'h5;
      txReq = 1'b0;
      arst_n = 1'b0;
      idle(20);
      arst_n = 1'b1;
      rx_frame(MLT_MODE_100TX, BIT_TIME_100_PS, RX_J_TO_CRS_MIN, RX_J_TO_CRS_MAX,
         RX_CRS_TO_DV_MIN, RX_CRS_TO_DV_MAX, TX_T_TO_CRS_OFF_MIN, TX_T_TO_CRS_OFF_MAX);
      rx_frame(MLT_MODE_100FX, BIT_TIME_100_PS, RX_J_TO_CRS_MIN, RX_J_TO_CRS_MAX,
         RX_CRS_TO_DV_MIN, RX_CRS_TO_DV_MAX, FX_T_TO_CRS_OFF_MIN, FX_T_TO_CRS_OFF_MAX);
      rx_frame(MLT_MODE_10T, BIT_TIME_10_PS, T10_IN_TO_CRS_MIN, T10_IN_TO_CRS_MAX,
         T10_CRS_TO_DV_MIN, T10_CRS_TO_DV_MAX, T10_QUIET_TO_CRS_MIN, T10_QUIET_TO_CRS_MAX);
      tx_frame(MLT_MODE_100TX, TX_EN_TO_CRS_MIN, TX_EN_TO_CRS_MAX, TX_EN_TO_CRS_OFF_MIN,
         TX_EN_TO_CRS_OFF_MAX, TX_EN_TO_LINE_MIN, TX_EN_TO_LINE_MAX);
      tx_frame(MLT_MODE_100FX, FX_EN_TO_CRS_MIN, FX_EN_TO_CRS_MAX, FX_EN_TO_CRS_OFF_MIN,
         FX_EN_TO_CRS_OFF_MAX, FX_EN_TO_LINE_MIN, FX_EN_TO_LINE_MAX);
      col_frame(MLT_MODE_100TX, BIT_TIME_100_PS, TX_J_TO_COL_MIN, TX_J_TO_COL_MAX,
         TX_T_TO_COL_OFF_MIN, TX_T_TO_COL_OFF_MAX);
      col_frame(MLT_MODE_100FX, BIT_TIME_100_PS, FX_J_TO_COL_MIN, FX_J_TO_COL_MAX,
         FX_T_TO_COL_OFF_MIN, FX_T_TO_COL_OFF_MAX);
      col_frame(MLT_MODE_10T, BIT_TIME_10_PS, T10_IN_TO_COL_MIN, T10_IN_TO_COL_MAX,
         T10_QUIET_TO_COL_MIN, T10_QUIET_TO_COL_MAX);
      complete_run();
   end
endmodule

// ===== rtl/mlt_delay_line.sv
// Programmable delay for a level: each edge of levelIn reaches levelOut after
// riseDly or fallDly cycles. Edges closer than the delay restart the count.
// Assumes all inputs on sys_clk.
`timescale 1ns/1ns
module mlt_delay_line
   import mlt_pkg::*;
(
   input wire logic sys_clk,
   input wire logic arst_n,
   input wire logic levelIn,
   input wire logic [DLY_W-1:0] riseDly,
   input wire logic [DLY_W-1:0] fallDly,
   output logic levelOut
);
   logic [DLY_W-1:0] cnt_reg;
   logic [DLY_W-1:0] cnt_next;
   logic out_reg;
   logic out_next;
   logic pending;
   logic change;

   assign pending = levelIn != out_reg;
   assign change = pending && (cnt_reg == DLY_W'(1));
   // Counter loads on the first cycle of a difference, then counts down
   assign cnt_next = !pending ? '0 :
                     (cnt_reg == '0) ? (levelIn ? riseDly : fallDly) - DLY_W'(1) :
                     cnt_reg - DLY_W'(1);
   assign out_next = (change || (pending && cnt_reg == '0 &&
                      (levelIn ? riseDly : fallDly) <= DLY_W'(1))) ? levelIn : out_reg;

   always_ff @(posedge sys_clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         cnt_reg <= '0;
         out_reg <= 1'b0;
      end
      else
      begin
         cnt_reg <= out_next != out_reg ? '0 : cnt_next;
         out_reg <= out_next;
      end
   end

   assign levelOut = out_reg;
endmodule

// ===== rtl/mlt_edge_sync.sv
// Two-flop synchroniser with rise and fall pulses taken after the second flop.
// Assumes an input asynchronous to sys_clk.
`timescale 1ns/1ns
module mlt_edge_sync
(
   input wire logic sys_clk,
   input wire logic arst_n,
   input wire logic asyncIn,
   output logic syncOut,
   output logic rise,
   output logic fall
);
   logic meta_reg;
   logic sync_reg;
   logic last_reg;

   always_ff @(posedge sys_clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         meta_reg <= 1'b0;
         sync_reg <= 1'b0;
         last_reg <= 1'b0;
      end
      else
      begin
         meta_reg <= asyncIn;
         sync_reg <= meta_reg;
         last_reg <= sync_reg;
      end
   end

   assign syncOut = sync_reg;
   assign rise = sync_reg & ~last_reg;
   assign fall = ~sync_reg & last_reg;
endmodule

// ===== rtl/mlt_mii_latency.sv
// MII-side latency shaper of a 10/100 PHY: takes the decoded line receive
// events and the MAC's transmit enable and produces carrier sense, collision,
// receive data and, at 100 Mb/s only, line transmit timing with the documented bit-time delays.
// Assumes line events are already on sys_clk; MAC signals and the MII
// transmit clock arrive from outside and are synchronised here.
`timescale 1ns/1ns

// Function
// - Latency counted in bit times; 10 ns at 100 Mb/s.
// - At 10 Mb/s one bit time is 100 ns.
// - 100 Mb/s receive data and valid 3-5 bit times after carrier sense.
// - 100 Mb/s carrier sense rises 12-16 bit times after start of J.
// - Copper 100 Mb/s carrier sense falls 10-17 bit times after start of T.
// - Fiber 100 Mb/s carrier sense falls 16-22 bit times after start of T.
// - Copper half-duplex collision rises 16-22 bit times after received J.
// - Fiber collision rises 10-15 bit times after received J while sending.
// - Copper collision falls 17-20 bit times after received T.
// - Fiber collision falls 14-18 bit times after received T.
// - Copper transmit carrier sense rises 20-24 bit times after enable sampled.
// - Fiber transmit carrier sense rises 17-20 bit times after enable sampled.
// - Copper transmit carrier sense falls 24-28 bit times after enable low.
// - Fiber transmit carrier sense falls 22-24 bit times after enable low.
// - Copper first line symbol 5.3-5.7 bit times after enable sampled high.
// - Fiber first line symbol 5-5.3 bit times after enable sampled high.
// - 10 Mb/s line data reaches receive data 4.2-6.6 bit times later.
// - 10 Mb/s data, valid and error active 5-32 bit times after carrier sense.
// - 10 Mb/s carrier sense falls 0.3-0.5 bit times after valid drops.
// - 10 Mb/s carrier sense rises 2-28 bit times after line activity begins.
// - 10 Mb/s carrier sense falls 6-10 bit times after line goes quiet.
// - 10 Mb/s collision rises 1-31 bit times after receive activity while sending.
// - 10 Mb/s collision falls 5-10 bit times after line goes quiet.
module mlt_mii_latency
   import mlt_pkg::*;
#(
   parameter int NIB_WIDTH = NIB_W,
   parameter int RX_PIPE = 128
)
(
   input wire logic sys_clk,
   input wire logic arst_n,
   input wire mlt_mode_t mode,
   input wire logic halfDuplex,
   input wire mlt_line_rx_t lineRx,
   input wire logic miiTxClk,
   input wire logic miiTxEn,
   output mlt_mii_rx_t miiRx,
   output logic miiCrs,
   output logic miiCol,
   output logic lineTxActive
);
   // ----------------------------------------------------------------
   // Parameter checks
   // ----------------------------------------------------------------
   if (NIB_WIDTH != NIB_W)
      $error("NIB_WIDTH must match the package nibble width");
   if (RX_PIPE < 8 || RX_PIPE > 256)
      $error("RX_PIPE out of supported range");

   // ----------------------------------------------------------------
   // Bit time selection
   // ----------------------------------------------------------------
   logic is10;
   logic isFx;
   int bitPs;

   assign is10 = mode == MLT_MODE_10T;
   assign isFx = mode == MLT_MODE_100FX;
   assign bitPs = is10 ? BIT_TIME_10_PS : BIT_TIME_100_PS;

   // ----------------------------------------------------------------
   // MAC transmit enable, sampled on rising edges of the MII clock
   // ----------------------------------------------------------------
   logic txClkRise;
   logic txEnSync;
   logic txEnSampled_reg;

   mlt_edge_sync uTxClk
   (
      .sys_clk(sys_clk),
      .arst_n(arst_n),
      .asyncIn(miiTxClk),
      .syncOut(),
      .rise(txClkRise),
      .fall()
   );

   mlt_edge_sync uTxEn
   (
      .sys_clk(sys_clk),
      .arst_n(arst_n),
      .asyncIn(miiTxEn),
      .syncOut(txEnSync),
      .rise(),
      .fall()
   );

   // Enable meets setup to the MII clock edge, so both arrive through equal
   // synchroniser depth and the sampled value lines up with that edge.
   always_ff @(posedge sys_clk or negedge arst_n)
   begin
      if (!arst_n)
         txEnSampled_reg <= 1'b0;
      else if (txClkRise)
         txEnSampled_reg <= txEnSync;
   end

   // ----------------------------------------------------------------
   // Receive stream activity from start and stop events
   // ----------------------------------------------------------------
   logic rxAct_reg;
   logic rxAct_next;

   // A start in the same cycle as a stop wins, so a back-to-back frame is kept
   assign rxAct_next = lineRx.start ? 1'b1 : lineRx.stop ? 1'b0 : rxAct_reg;

   always_ff @(posedge sys_clk or negedge arst_n)
   begin
      if (!arst_n)
         rxAct_reg <= 1'b0;
      else
         rxAct_reg <= rxAct_next;
   end

   // ----------------------------------------------------------------
   // Delay selections per mode
   // ----------------------------------------------------------------
   logic [DLY_W-1:0] rxCrsOn;
   logic [DLY_W-1:0] rxCrsOff;
   logic [DLY_W-1:0] colOn;
   logic [DLY_W-1:0] colOff;
   logic [DLY_W-1:0] txCrsOn;
   logic [DLY_W-1:0] txCrsOff;
   logic [DLY_W-1:0] lineOn;
   logic [DLY_W-1:0] dvOn;
   logic [DLY_W-1:0] dataDly;
   logic [DLY_W-1:0] crsTail;

   assign rxCrsOn = is10 ? mlt_cycles(T10_IN_TO_CRS_MIN, T10_IN_TO_CRS_MAX, bitPs)
                    : mlt_cycles(RX_J_TO_CRS_MIN, RX_J_TO_CRS_MAX, bitPs);
   assign rxCrsOff = is10 ? mlt_cycles(T10_QUIET_TO_CRS_MIN, T10_QUIET_TO_CRS_MAX, bitPs)
                     : isFx ? mlt_cycles(FX_T_TO_CRS_OFF_MIN, FX_T_TO_CRS_OFF_MAX, bitPs)
                     : mlt_cycles(TX_T_TO_CRS_OFF_MIN, TX_T_TO_CRS_OFF_MAX, bitPs);
   assign colOn = is10 ? mlt_cycles(T10_IN_TO_COL_MIN, T10_IN_TO_COL_MAX, bitPs)
                  : isFx ? mlt_cycles(FX_J_TO_COL_MIN, FX_J_TO_COL_MAX, bitPs)
                  : mlt_cycles(TX_J_TO_COL_MIN, TX_J_TO_COL_MAX, bitPs);
   assign colOff = is10 ? mlt_cycles(T10_QUIET_TO_COL_MIN, T10_QUIET_TO_COL_MAX, bitPs)
                   : isFx ? mlt_cycles(FX_T_TO_COL_OFF_MIN, FX_T_TO_COL_OFF_MAX, bitPs)
                   : mlt_cycles(TX_T_TO_COL_OFF_MIN, TX_T_TO_COL_OFF_MAX, bitPs);
   assign txCrsOn = isFx ? mlt_cycles(FX_EN_TO_CRS_MIN, FX_EN_TO_CRS_MAX, bitPs)
                    : mlt_cycles(TX_EN_TO_CRS_MIN, TX_EN_TO_CRS_MAX, bitPs);
   assign txCrsOff = isFx ? mlt_cycles(FX_EN_TO_CRS_OFF_MIN, FX_EN_TO_CRS_OFF_MAX, bitPs)
                     : mlt_cycles(TX_EN_TO_CRS_OFF_MIN, TX_EN_TO_CRS_OFF_MAX, bitPs);
   assign lineOn = isFx ? mlt_cycles(FX_EN_TO_LINE_MIN, FX_EN_TO_LINE_MAX, bitPs)
                   : mlt_cycles(TX_EN_TO_LINE_MIN, TX_EN_TO_LINE_MAX, bitPs);
   assign dvOn = is10 ? mlt_cycles(T10_CRS_TO_DV_MIN, T10_CRS_TO_DV_MAX, bitPs)
                 : mlt_cycles(RX_CRS_TO_DV_MIN, RX_CRS_TO_DV_MAX, bitPs);
   assign dataDly = mlt_cycles(T10_RX_DATA_MIN, T10_RX_DATA_MAX, bitPs);
   assign crsTail = mlt_cycles(T10_DV_OFF_TO_CRS_MIN, T10_DV_OFF_TO_CRS_MAX, bitPs);

   // ----------------------------------------------------------------
   // Receive and transmit carrier sense, collision and line transmit delays
   // ----------------------------------------------------------------
   logic rxCrs;
   logic colSrc;
   logic colLvl;
   logic txCrs;

   mlt_delay_line uRxCrs
   (
      .sys_clk(sys_clk),
      .arst_n(arst_n),
      .levelIn(rxAct_reg),
      .riseDly(rxCrsOn),
      .fallDly(rxCrsOff),
      .levelOut(rxCrs)
   );

   // Collision only exists while transmitting in half duplex
   assign colSrc = rxAct_reg && txEnSampled_reg && halfDuplex;

   mlt_delay_line uCol
   (
      .sys_clk(sys_clk),
      .arst_n(arst_n),
      .levelIn(colSrc),
      .riseDly(colOn),
      .fallDly(colOff),
      .levelOut(colLvl)
   );

   // 10 Mb/s echoes of transmit are not reported on carrier sense here
   mlt_delay_line uTxCrs
   (
      .sys_clk(sys_clk),
      .arst_n(arst_n),
      .levelIn(txEnSampled_reg && !is10),
      .riseDly(txCrsOn),
      .fallDly(txCrsOff),
      .levelOut(txCrs)
   );

   mlt_delay_line uLine
   (
      .sys_clk(sys_clk),
      .arst_n(arst_n),
      .levelIn(txEnSampled_reg && !is10),
      .riseDly(lineOn),
      .fallDly(DLY_W'(1)),
      .levelOut(lineTxActive)
   );

   // ----------------------------------------------------------------
   // Receive data path: delay line for nibbles, gated by valid window
   // ----------------------------------------------------------------
   logic [NIB_W+1:0] pipe_reg [RX_PIPE];
   logic dvGate;
   logic [NIB_W+1:0] pipeOut;
   logic [$clog2(RX_PIPE)-1:0] tap;

   genvar gi;
   for (gi = 0; gi < RX_PIPE; gi++)
   begin : gPipe
      always_ff @(posedge sys_clk or negedge arst_n)
      begin
         if (!arst_n)
            pipe_reg[gi] <= '0;
         else if (gi == 0)
            pipe_reg[gi] <= {lineRx.valid, lineRx.err, lineRx.data};
         else
            pipe_reg[gi] <= pipe_reg[gi-1];
      end
   end

   // Line data latency only governs 10 Mb/s; 100 Mb/s uses the shortest tap.
   // The pipe must reach the full 10 Mb/s data delay, or carrier sense
   // cannot trail valid by a short tail and still meet its quiet window.
   assign tap = is10 ? (dataDly >= DLY_W'(RX_PIPE) ? $clog2(RX_PIPE)'(RX_PIPE - 1)
                        : $clog2(RX_PIPE)'(dataDly - DLY_W'(1))) : '0;
   assign pipeOut = pipe_reg[tap];

   mlt_delay_line uDv
   (
      .sys_clk(sys_clk),
      .arst_n(arst_n),
      .levelIn(rxCrs),
      .riseDly(dvOn),
      .fallDly(DLY_W'(1)),
      .levelOut(dvGate)
   );

   // ----------------------------------------------------------------
   // Outputs
   // ----------------------------------------------------------------
   mlt_mii_rx_t rx_reg;
   mlt_mii_rx_t rx_next;
   logic crs_reg;
   logic crsTailCnt_reg_on;
   logic [DLY_W-1:0] tail_reg;
   logic [DLY_W-1:0] tail_next;
   logic rxCrsHold;
   logic dvOff_reg;
   logic dvOff_next;

   assign rx_next.dv = dvGate && rxCrs && pipeOut[NIB_W+1];
   assign rx_next.er = dvGate && rxCrs && pipeOut[NIB_W];
   assign rx_next.data = (dvGate && rxCrs) ? pipeOut[NIB_W-1:0] : '0;

   // At 10 Mb/s carrier sense trails valid by a short tail
   assign tail_next = (rx_reg.dv && !rx_next.dv && is10) ? crsTail :
                      (tail_reg != '0) ? tail_reg - DLY_W'(1) : '0;
   // At 10 Mb/s the end of valid after line quiet releases carrier sense
   assign dvOff_next = (is10 && rx_reg.dv && !rx_next.dv && !rxAct_reg) ? 1'b1 :
                       lineRx.start ? 1'b0 : dvOff_reg;
   assign rxCrsHold = (rxCrs && !dvOff_reg) || (tail_reg != '0);
   assign crsTailCnt_reg_on = rxCrsHold || txCrs;

   always_ff @(posedge sys_clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         rx_reg <= '0;
         tail_reg <= '0;
         crs_reg <= 1'b0;
         dvOff_reg <= 1'b0;
      end
      else
      begin
         rx_reg <= rx_next;
         tail_reg <= tail_next;
         dvOff_reg <= dvOff_next;
         crs_reg <= crsTailCnt_reg_on;
      end
   end

   assign miiRx = rx_reg;
   assign miiCrs = crs_reg;
   assign miiCol = colLvl;
endmodule

// ===== rtl/mlt_pkg.sv
// Package for the MII latency timing block: modes, bit times, latency windows.
// Assumes a 125 MHz system clock.
package mlt_pkg;
   // ----------------------------------------------------------------
   // Clock and bit times
   // ----------------------------------------------------------------
   localparam int SYS_CLK_PS = 8000;
   localparam int BIT_TIME_100_PS = 10000;
   localparam int BIT_TIME_10_PS = 100000;

   // ----------------------------------------------------------------
   // Latency windows in tenths of a bit time (min, max)
   // ----------------------------------------------------------------
   localparam int RX_CRS_TO_DV_MIN = 30;
   localparam int RX_CRS_TO_DV_MAX = 50;
   localparam int RX_J_TO_CRS_MIN = 120;
   localparam int RX_J_TO_CRS_MAX = 160;
   localparam int TX_T_TO_CRS_OFF_MIN = 100;
   localparam int TX_T_TO_CRS_OFF_MAX = 170;
   localparam int FX_T_TO_CRS_OFF_MIN = 160;
   localparam int FX_T_TO_CRS_OFF_MAX = 220;
   localparam int TX_J_TO_COL_MIN = 160;
   localparam int TX_J_TO_COL_MAX = 220;
   localparam int FX_J_TO_COL_MIN = 100;
   localparam int FX_J_TO_COL_MAX = 150;
   localparam int TX_T_TO_COL_OFF_MIN = 170;
   localparam int TX_T_TO_COL_OFF_MAX = 200;
   localparam int FX_T_TO_COL_OFF_MIN = 140;
   localparam int FX_T_TO_COL_OFF_MAX = 180;
   localparam int TX_EN_TO_CRS_MIN = 200;
   localparam int TX_EN_TO_CRS_MAX = 240;
   localparam int FX_EN_TO_CRS_MIN = 170;
   localparam int FX_EN_TO_CRS_MAX = 200;
   localparam int TX_EN_TO_CRS_OFF_MIN = 240;
   localparam int TX_EN_TO_CRS_OFF_MAX = 280;
   localparam int FX_EN_TO_CRS_OFF_MIN = 220;
   localparam int FX_EN_TO_CRS_OFF_MAX = 240;
   localparam int TX_EN_TO_LINE_MIN = 53;
   localparam int TX_EN_TO_LINE_MAX = 57;
   localparam int FX_EN_TO_LINE_MIN = 50;
   localparam int FX_EN_TO_LINE_MAX = 53;
   localparam int T10_RX_DATA_MIN = 42;
   localparam int T10_RX_DATA_MAX = 66;
   localparam int T10_CRS_TO_DV_MIN = 50;
   localparam int T10_CRS_TO_DV_MAX = 320;
   localparam int T10_DV_OFF_TO_CRS_MIN = 3;
   localparam int T10_DV_OFF_TO_CRS_MAX = 5;
   localparam int T10_IN_TO_CRS_MIN = 20;
   localparam int T10_IN_TO_CRS_MAX = 280;
   localparam int T10_QUIET_TO_CRS_MIN = 60;
   localparam int T10_QUIET_TO_CRS_MAX = 100;
   localparam int T10_IN_TO_COL_MIN = 10;
   localparam int T10_IN_TO_COL_MAX = 310;
   localparam int T10_QUIET_TO_COL_MIN = 50;
   localparam int T10_QUIET_TO_COL_MAX = 100;

   // Delay counter width; 10 Mb/s worst case is 32 bit times = 400 cycles
   localparam int DLY_W = 10;
   localparam int NIB_W = 4;

   // Cycles for a target in tenths of a bit time, midway in the window.
   // Midpoint keeps rounding margin on both sides; at least one cycle.
   function automatic logic [DLY_W-1:0] mlt_cycles(input int minT, input int maxT,
                                                   input int bitPs);
      int ps;
      int cyc;
      begin
         ps = ((minT + maxT) * bitPs) / 20;
         cyc = (ps + SYS_CLK_PS / 2) / SYS_CLK_PS;
         if (cyc < 1)
            cyc = 1;
         mlt_cycles = DLY_W'(cyc);
      end
   endfunction

   typedef enum logic [1:0] {
      MLT_MODE_100TX = 2'b00,
      MLT_MODE_100FX = 2'b01,
      MLT_MODE_10T = 2'b11
   } mlt_mode_t;

   // Line receive side after decoding: stream start, stream end, nibble
   typedef struct packed {
      logic start;
      logic stop;
      logic valid;
      logic err;
      logic [NIB_W-1:0] data;
   } mlt_line_rx_t;

   // MII receive group toward the MAC
   typedef struct packed {
      logic dv;
      logic er;
      logic [NIB_W-1:0] data;
   } mlt_mii_rx_t;
endpackage
